// file: design/mssp_pkg.sv
// Constants and types of the master serial shift port
// Behaviour
// R1: With the port enable bit (control bit 7) set, a byte written to the data register is loaded and shifted out MSB first under a serial clock this port drives.
// R2: The port is full duplex on one clock, the received byte replaces the sent one, and there are no separate transmit-empty or receive-full flags.
// R3: After eight serial clock cycles the received byte is copied in parallel to a read buffer that the next data register read returns.
// R4: The busy bit (control bit 4) stays set for as long as a byte transfer is in progress.
// R5: The port is always master and makes the serial clock, and the peripheral returns data on the serial input line in step with it.
// R6: Serial clock polarity and phase are programmable so sampling and shifting edges suit the peripheral.
// R7: Two rate bits select the divider from the core clock: 00 by 8, 01 by 16, 10 by 128, 11 by 256.
// R8: In two-wire bus mode the port honours clock slowdown by other devices and flags arbitration loss, with the data lines wire-ANDed outside.
// R9: The interrupt source is the external channel pin (enable 0, bus mode 0), bus start or stop (enable 0, bus mode 1) or end of byte (enable 1).
// R10: Software masks the shared external channel and clears its pending bit before enabling the port, which uses that channel's priority.
// R11: The data register sits at register 253 and the control register at register 254 in I/O page zero.
// R12: The clock idles at the polarity level, and data is sampled on the first edge with phase 0 or the second edge with phase 1.
package mssp_pkg;

   // Register offsets
   localparam logic [7:0] REG_IRQ_STAT = 8'hfb;
   localparam logic [7:0] REG_IRQ_MASK = 8'hfc;
   localparam logic [7:0] REG_DATA = 8'hfd;
   localparam logic [7:0] REG_CTRL = 8'hfe;

   // Control register field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_BM_BIT = 6;
   localparam int CTRL_CPOL_BIT = 5;
   localparam int CTRL_BUSY_BIT = 4;
   localparam int CTRL_CPHA_BIT = 3;
   localparam int CTRL_RATE_HI_BIT = 1;
   localparam int CTRL_RATE_LO_BIT = 0;

   // Interrupt status and mask field positions
   localparam int IRQ_BYTE_DONE_BIT = 0;
   localparam int IRQ_START_STOP_BIT = 1;
   localparam int IRQ_EXT_CHAN_BIT = 2;
   localparam int IRQ_ARB_LOST_BIT = 3;
   localparam int IRQ_W = 4;

   // Values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] IRQ_STAT_RESET = 4'h0;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [7:0] RX_BUF_RESET = 8'h00;

   // Serial clock dividers of the core clock, and half periods in cycles
   localparam int DIV_R00 = 8;
   localparam int DIV_R01 = 16;
   localparam int DIV_R10 = 128;
   localparam int DIV_R11 = 256;
   localparam logic [7:0] HALF_R00 = 8'(DIV_R00 / 2);
   localparam logic [7:0] HALF_R01 = 8'(DIV_R01 / 2);
   localparam logic [7:0] HALF_R10 = 8'(DIV_R10 / 2);
   localparam logic [7:0] HALF_R11 = 8'(DIV_R11 / 2);

   // Eight serial clock cycles make sixteen clock edges
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

   typedef struct packed {
      logic en;
      logic bus_mode;
      logic cpol;
      logic busy;
      logic cpha;
      logic rsv;
      logic [1:0] rate;
   } mssp_ctrl_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic ext;
   } mssp_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } mssp_state_t;

endpackage

// file: design/mssp_top.sv
// Master serial shift port: register slave, clock divider, shifter and interrupt logic
`timescale 1ns/1ps
module mssp_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial clock, open drain in bus mode
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   // Serial data
   output logic serial_out_line,
   input wire logic serial_in_line,
   // Shared external interrupt channel pin
   input wire logic shared_ext_irq_channel,
   // Interrupt
   output logic irq
);

   if (ADDR_W < 8) begin : g_addr_check
      $error("mssp_top: ADDR_W must be at least 8");
   end

   mssp_pkg::mssp_ctrl_t ctrl_q;
   mssp_pkg::mssp_state_t state_q;
   mssp_pkg::mssp_pins_t sync1_q;
   mssp_pkg::mssp_pins_t sync2_q;
   mssp_pkg::mssp_pins_t prev_q;

   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic [7:0] rx_buf_q;
   logic [4:0] edge_cnt_q;
   logic [7:0] div_cnt_q;
   logic [7:0] half_sel;
   logic sck_level_q;
   logic sck_level_d;
   logic sdo_q;
   logic [3:0] irq_stat_q;
   logic [3:0] irq_mask_q;
   logic [3:0] irq_evt;
   logic [3:0] irq_clr;
   logic [7:0] rdata_q;
   logic sck_out_q;
   logic sck_oe_q;
   logic irq_q;

   logic sel_data;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_mask;
   logic start_xfer;
   logic stretch;
   logic tick;
   logic leading;
   logic sample_edge;
   logic last_edge;
   logic arb_lost;
   logic abort;
   logic busy;
   logic bus_start;
   logic bus_stop;
   logic ext_rise;

   // Address decode
   assign sel_data = (reg_addr == ADDR_W'(mssp_pkg::REG_DATA)); // R11
   assign sel_ctrl = (reg_addr == ADDR_W'(mssp_pkg::REG_CTRL)); // R11
   assign sel_stat = (reg_addr == ADDR_W'(mssp_pkg::REG_IRQ_STAT));
   assign sel_mask = (reg_addr == ADDR_W'(mssp_pkg::REG_IRQ_MASK));

   assign busy = (state_q != mssp_pkg::ST_IDLE); // R4

   // A data write while enabled and idle starts a byte
   assign start_xfer = reg_wr && sel_data && ctrl_q.en && !busy; // R1

   // Pin synchronisers; only the second stage and its delayed copy prev_q are read
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= '{scl: sck_in, sda: serial_in_line, ext: shared_ext_irq_channel};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Control register; the busy bit is status only
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_q <= mssp_pkg::CTRL_RESET;
      end else if (reg_wr && sel_ctrl) begin
         ctrl_q.en <= reg_wdata[mssp_pkg::CTRL_EN_BIT]; // R1
         ctrl_q.bus_mode <= reg_wdata[mssp_pkg::CTRL_BM_BIT]; // R8
         ctrl_q.cpol <= reg_wdata[mssp_pkg::CTRL_CPOL_BIT]; // R6
         ctrl_q.cpha <= reg_wdata[mssp_pkg::CTRL_CPHA_BIT]; // R6
         ctrl_q.rate <= {reg_wdata[mssp_pkg::CTRL_RATE_HI_BIT],
                         reg_wdata[mssp_pkg::CTRL_RATE_LO_BIT]}; // R7
      end
   end

   // Half period of the serial clock in core cycles
   always_comb begin
      unique case (ctrl_q.rate) // R7
         2'b00: half_sel = mssp_pkg::HALF_R00;
         2'b01: half_sel = mssp_pkg::HALF_R01;
         2'b10: half_sel = mssp_pkg::HALF_R10;
         2'b11: half_sel = mssp_pkg::HALF_R11;
      endcase
   end

   // Bus mode: a released clock held low by another device stalls the divider
   assign stretch = ctrl_q.bus_mode && sck_level_q && !sync2_q.scl; // R8

   assign tick = (state_q == mssp_pkg::ST_RUN) && !stretch
                 && (div_cnt_q == half_sel - 8'h01);

   // Edge 0 is the leading edge of the first serial clock cycle
   assign leading = !edge_cnt_q[0];
   assign sample_edge = leading ^ ctrl_q.cpha; // R12
   assign last_edge = (edge_cnt_q == mssp_pkg::EDGES_PER_BYTE - 5'h01); // R3

   // Bus mode: a released one read back as zero loses the bus
   assign arb_lost = tick && sample_edge && ctrl_q.bus_mode
                     && sdo_q && !sync2_q.sda; // R8
   assign abort = (state_q == mssp_pkg::ST_RUN) && (arb_lost || !ctrl_q.en);

   // Divider producing one enable pulse per half period
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         div_cnt_q <= 8'h00;
      end else if (state_q != mssp_pkg::ST_RUN || tick) begin
         div_cnt_q <= 8'h00;
      end else if (!stretch) begin
         div_cnt_q <= div_cnt_q + 8'h01; // R7
      end
   end

   // Transfer sequencer
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_q <= mssp_pkg::ST_IDLE;
         edge_cnt_q <= 5'h00;
      end else begin
         unique case (state_q)
            mssp_pkg::ST_IDLE: begin
               edge_cnt_q <= 5'h00;
               if (start_xfer) begin
                  state_q <= mssp_pkg::ST_RUN; // R4
               end
            end
            mssp_pkg::ST_RUN: begin
               if (abort) begin
                  state_q <= mssp_pkg::ST_IDLE;
               end else if (tick) begin
                  edge_cnt_q <= edge_cnt_q + 5'h01;
                  if (last_edge) begin
                     state_q <= mssp_pkg::ST_DONE; // R3
                  end
               end
            end
            mssp_pkg::ST_DONE: begin
               state_q <= mssp_pkg::ST_IDLE;
            end
            default: begin
               state_q <= mssp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Serial clock level: idles at polarity, toggles on each half period
   always_comb begin
      sck_level_d = sck_level_q;
      if (state_q != mssp_pkg::ST_RUN || abort) begin
         sck_level_d = ctrl_q.cpol; // R12
      end else if (tick) begin
         sck_level_d = !sck_level_q; // R5
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sck_level_q <= 1'b0;
      end else begin
         sck_level_q <= sck_level_d;
      end
   end

   // Clock pin: push-pull normally, drive-low-only in bus mode
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sck_out_q <= 1'b0;
         sck_oe_q <= 1'b0;
      end else begin
         sck_out_q <= ctrl_q.bus_mode ? 1'b0 : sck_level_d; // R5
         sck_oe_q <= ctrl_q.en && (!ctrl_q.bus_mode || !sck_level_d); // R8
      end
   end

   // Transmit shifter, MSB first
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tx_q <= 8'h00;
         sdo_q <= 1'b1;
      end else if (start_xfer) begin
         tx_q <= reg_wdata; // R1
         sdo_q <= ctrl_q.cpha ? 1'b1 : reg_wdata[7]; // R12
      end else if (abort || state_q == mssp_pkg::ST_DONE) begin
         sdo_q <= 1'b1;
      end else if (tick && !sample_edge) begin
         if (ctrl_q.cpha) begin
            sdo_q <= tx_q[7]; // R1
            tx_q <= {tx_q[6:0], 1'b0};
         end else if (!last_edge) begin
            sdo_q <= tx_q[6]; // R1
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Receive shifter on the sampling edges, same clock as transmit
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_q <= 8'h00;
      end else if (tick && sample_edge && state_q == mssp_pkg::ST_RUN) begin
         rx_q <= {rx_q[6:0], sync2_q.sda}; // R2
      end
   end

   // Read buffer loaded in parallel at the end of the byte
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_buf_q <= mssp_pkg::RX_BUF_RESET;
      end else if (state_q == mssp_pkg::ST_DONE) begin
         rx_buf_q <= rx_q; // R3
      end
   end

   // Bus start and stop while the port is off
   assign bus_start = sync2_q.scl && prev_q.scl && prev_q.sda && !sync2_q.sda;
   assign bus_stop = sync2_q.scl && prev_q.scl && !prev_q.sda && sync2_q.sda;
   assign ext_rise = sync2_q.ext && !prev_q.ext;

   // Interrupt source selection by enable and bus mode
   always_comb begin
      irq_evt = '0;
      irq_evt[mssp_pkg::IRQ_BYTE_DONE_BIT] = ctrl_q.en
                                             && (state_q == mssp_pkg::ST_DONE); // R9
      irq_evt[mssp_pkg::IRQ_START_STOP_BIT] = !ctrl_q.en && ctrl_q.bus_mode
                                              && (bus_start || bus_stop); // R9
      irq_evt[mssp_pkg::IRQ_EXT_CHAN_BIT] = !ctrl_q.en && !ctrl_q.bus_mode
                                            && ext_rise; // R9
      irq_evt[mssp_pkg::IRQ_ARB_LOST_BIT] = ctrl_q.en && arb_lost; // R8
   end

   assign irq_clr = (reg_wr && sel_stat) ? reg_wdata[3:0] : 4'h0;

   // Sticky status, write one to clear, a new event wins
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_stat_q <= mssp_pkg::IRQ_STAT_RESET;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_mask_q <= mssp_pkg::IRQ_MASK_RESET;
      end else if (reg_wr && sel_mask) begin
         irq_mask_q <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Read data, valid only in the cycle after the read strobe
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         if (sel_data) begin
            rdata_q <= rx_buf_q; // R3
         end else if (sel_ctrl) begin
            rdata_q <= {ctrl_q.en, ctrl_q.bus_mode, ctrl_q.cpol, busy,
                        ctrl_q.cpha, 1'b0, ctrl_q.rate}; // R4
         end else if (sel_stat) begin
            rdata_q <= {4'h0, irq_stat_q};
         end else if (sel_mask) begin
            rdata_q <= {4'h0, irq_mask_q};
         end else begin
            rdata_q <= 8'h00;
         end
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;
   assign sck_out = sck_out_q;
   assign sck_oe = sck_oe_q;
   assign serial_out_line = sdo_q;
   assign irq = irq_q;

endmodule

// file: verification/mssp_properties.sv
// Concurrent checks on the ports of the serial shift port
`timescale 1ns/1ps
module mssp_checker #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Serial pins
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_out_line
);
   logic en_q, bm_q, cpha_q, act_q, sck_q;
   logic [1:0] rate_q;
   logic [4:0] edges_q;
   logic ctrl_wr, start, sck_chg;
   assign ctrl_wr = reg_wr && reg_addr == ADDR_W'(mssp_pkg::REG_CTRL);
   assign start = reg_wr && reg_addr == ADDR_W'(mssp_pkg::REG_DATA) && en_q && !bm_q && !act_q;
   assign sck_chg = sck_out != sck_q;
   // Shadow of the control fields
   always_ff @(posedge clk_sys) begin
      sck_q <= sck_out;
      if (!resetn) begin
         {en_q, bm_q, cpha_q, rate_q} <= 5'h00;
      end else if (ctrl_wr) begin
         {en_q, bm_q, cpha_q, rate_q} <= {reg_wdata[7:6], reg_wdata[3], reg_wdata[1:0]};
      end
   end
   // Byte in flight and its clock edges
   always_ff @(posedge clk_sys) begin
      if (!resetn || (ctrl_wr && !reg_wdata[7])) begin
         act_q <= 1'b0;
         edges_q <= 5'h00;
      end else if (start) begin
         act_q <= 1'b1;
         edges_q <= 5'h00;
      end else if (act_q && sck_chg) begin
         edges_q <= edges_q + 5'h01;
         act_q <= edges_q != 5'h0f;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_quiet;
      !sck_chg [*3];
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside answer");
   a_unmapped_read: assert property (reg_rd && (reg_addr < ADDR_W'(mssp_pkg::REG_IRQ_STAT)
      || reg_addr > ADDR_W'(mssp_pkg::REG_CTRL)) |=> reg_rdata == 8'h00) else $error("unmapped read");
   a_disable_quiet: assert property (ctrl_wr && !reg_wdata[7] |-> ##[1:2] (!sck_oe && serial_out_line))
      else $error("port not released");
   a_enable_drive: assert property (ctrl_wr && reg_wdata[7:6] == 2'b10 |-> ##[1:2] sck_oe)
      else $error("clock not driven");
   a_bus_clock_low: assert property (bm_q && $past(bm_q, 2) |-> !sck_out) else $error("bus clock high");
   a_msb_first: assert property (start && !cpha_q |=> serial_out_line == $past(reg_wdata[7]))
      else $error("first bit wrong");
   a_half_period: assert property (sck_chg && act_q && rate_q == 2'b00 && edges_q < 5'h0f
      |=> s_quiet ##1 sck_chg) else $error("half period wrong");
   a_byte_length: assert property (sck_chg && act_q && edges_q == 5'h0f |=> s_quiet)
      else $error("extra clock edge");
   a_idle_data: assert property (!act_q && $past(!act_q, 4) |-> serial_out_line)
      else $error("data line not idle");
endmodule

// file: verification/mssp_peer_model.sv
// Serial peripheral model answering the port's shifts
`timescale 1ns/1ps
module mssp_peer_model (
   // Clock and mode
   input wire logic clk_sys,
   input wire logic cpol,
   input wire logic cpha,
   // Serial lines
   input wire logic sck,
   input wire logic sel,
   input wire logic mosi,
   output logic miso,
   // Bytes
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] sh;
   logic sck_q = 1'b0;
   logic act = 1'b0;
   logic lead, trail;
   initial miso = 1'b0;
   assign lead = sck_q == cpol && sck != cpol;
   assign trail = sck_q != cpol && sck == cpol;
   always @(posedge clk_sys) begin
      sck_q <= sck;
      if (!sel) begin
         // Unselected line shows a moving pattern
         miso <= ~miso;
         sh <= tx_byte;
         act <= 1'b0;
      end else if (!act) begin
         miso <= sh[7];
         act <= 1'b1;
      end else if ((lead && cpha) || (trail && !cpha)) begin
         miso <= cpha ? sh[7] : sh[6];
         sh <= {sh[6:0], 1'b0};
      end
      if (sel && ((lead && !cpha) || (trail && cpha))) begin
         rx_byte <= {rx_byte[6:0], mosi};
      end
   end
endmodule

// file: verification/tb_master_serial_shift_port.sv
// Testbench of the serial shift port against a peripheral model
`timescale 1ns/1ps
module tb_master_serial_shift_port;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic shared_ext_irq_channel = 1'b0;
   logic sel = 1'b0;
   logic [1:0] mode = 2'b00;
   logic [7:0] slv_tx = 8'h00;
   logic [7:0] reg_rdata, slv_rx;
   logic sck_in, sck_out, sck_oe, serial_out_line, serial_in_line, irq;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   // Pull-up on the clock wire
   assign sck_in = sck_oe ? sck_out : 1'b1;
   always #5 clk_sys = ~clk_sys;
   mssp_top uut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sck_in, .sck_out, .sck_oe, .serial_out_line, .serial_in_line, .shared_ext_irq_channel, .irq);
   mssp_peer_model peer (.clk_sys, .cpol(mode[1]), .cpha(mode[0]), .sck(sck_in), .sel,
      .mosi(serial_out_line), .miso(serial_in_line), .tx_byte(slv_tx), .rx_byte(slv_rx));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         finish_test;
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(name, exp, d);
   endtask
   task automatic pulse_ext;
      repeat (4) @(posedge clk_sys) shared_ext_irq_channel <= 1'b1;
      repeat (6) @(posedge clk_sys) shared_ext_irq_channel <= 1'b0;
   endtask
   task automatic t_reset;
      rchk("control", mssp_pkg::REG_CTRL, mssp_pkg::CTRL_RESET);
      rchk("status", mssp_pkg::REG_IRQ_STAT, 8'h00);
      rchk("mask", mssp_pkg::REG_IRQ_MASK, 8'h00);
      rchk("data", mssp_pkg::REG_DATA, mssp_pkg::RX_BUF_RESET);
      rchk("unmapped", 8'h10, 8'h00);
      chk("clock enable", 8'h00, {7'h00, sck_oe});
      $display("test reset done");
   endtask
   task automatic t_ext;
      wr(mssp_pkg::REG_IRQ_MASK, 8'h04);
      wr(mssp_pkg::REG_CTRL, 8'h40);
      pulse_ext;
      rchk("bus mode source", mssp_pkg::REG_IRQ_STAT, 8'h02);
      chk("irq masked source", 8'h00, {7'h00, irq});
      wr(mssp_pkg::REG_CTRL, 8'h00);
      wr(mssp_pkg::REG_IRQ_STAT, 8'h06);
      pulse_ext;
      rchk("pin source", mssp_pkg::REG_IRQ_STAT, 8'h04);
      chk("irq raised", 8'h01, {7'h00, irq});
      wr(mssp_pkg::REG_IRQ_MASK, 8'h00);
      rchk("still pending", mssp_pkg::REG_IRQ_STAT, 8'h04);
      chk("irq masked", 8'h00, {7'h00, irq});
      wr(mssp_pkg::REG_IRQ_STAT, 8'h04);
      rchk("pin cleared", mssp_pkg::REG_IRQ_STAT, 8'h00);
      $display("test interrupt sources done");
   endtask
   task automatic t_xfer(input logic [1:0] m, input logic [1:0] r, input logic [7:0] tx,
      input logic [7:0] rx);
      logic [7:0] d;
      logic [7:0] ctl;
      int h, t0, n;
      h = r == 2'b00 ? mssp_pkg::HALF_R00 : r == 2'b01 ? mssp_pkg::HALF_R01 :
         r == 2'b10 ? mssp_pkg::HALF_R10 : mssp_pkg::HALF_R11;
      ctl = {1'b1, 1'b0, m[1], 1'b0, m[0], 1'b0, r};
      n = 0;
      mode <= m;
      slv_tx <= rx;
      wr(mssp_pkg::REG_IRQ_MASK, 8'h01);
      wr(mssp_pkg::REG_IRQ_STAT, 8'h0f);
      wr(mssp_pkg::REG_CTRL, ctl);
      // The clock pin follows a new polarity one edge after the control write
      @(posedge clk_sys);
      #1;
      chk("idle clock", {7'h00, m[1]}, {7'h00, sck_out});
      sel <= 1'b1;
      wr(mssp_pkg::REG_DATA, tx);
      t0 = cycles;
      wr(mssp_pkg::REG_DATA, ~tx);
      rchk("busy", mssp_pkg::REG_CTRL, ctl | 8'h10);
      do begin
         rd(mssp_pkg::REG_CTRL, d);
         n++;
      end while (d[4] !== 1'b0 && n < 2000);
      chk("duration", 8'h01, {7'h00, cycles - t0 >= 16 * h && cycles - t0 <= 16 * h + 12});
      sel <= 1'b0;
      rchk("received byte", mssp_pkg::REG_DATA, rx);
      chk("peer byte", tx, slv_rx);
      rchk("byte done", mssp_pkg::REG_IRQ_STAT, 8'h01);
      chk("done irq", 8'h01, {7'h00, irq});
      chk("clock after", {7'h00, m[1]}, {7'h00, sck_out});
      $display("test transfer mode %0d rate %0d done", m, r);
   endtask
   task automatic t_abort;
      mode <= 2'b00;
      wr(mssp_pkg::REG_IRQ_STAT, 8'h0f);
      wr(mssp_pkg::REG_CTRL, 8'h81);
      sel <= 1'b1;
      wr(mssp_pkg::REG_DATA, 8'h3c);
      repeat (40) @(posedge clk_sys);
      wr(mssp_pkg::REG_CTRL, 8'h01);
      rchk("abort busy", mssp_pkg::REG_CTRL, 8'h01);
      chk("abort clock", 8'h00, {7'h00, sck_out});
      rchk("buffer kept", mssp_pkg::REG_DATA, 8'h5a ^ 8'h07);
      rchk("no byte done", mssp_pkg::REG_IRQ_STAT, 8'h00);
      sel <= 1'b0;
      $display("test abort done");
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset;
      t_ext;
      for (int i = 0; i < 8; i++) begin
         t_xfer(2'(i), i < 4 ? 2'b00 : 2'(i), 8'h81 + 8'(i), 8'h5a ^ 8'(i));
      end
      t_abort;
      finish_test;
   end
endmodule
bind mssp_top mssp_checker #(.ADDR_W(ADDR_W)) chk_i (.clk_sys, .resetn, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .sck_out, .sck_oe, .serial_out_line);
